/* File: dv/ipf_chk.sv */
// Checker: port-level assertions for the interrupt pending-flag block
`timescale 1ns/100ps
`default_nettype none
module ipf_chk
  import ipf_pkg::*;
(
  // Clock, reset and bus
  input wire logic                clk_in,
  input wire logic                rst_in,
  input wire logic                hsel_in,
  input wire logic [31:0]         haddr_in,
  input wire logic [1:0]          htrans_in,
  input wire logic                hwrite_in,
  input wire logic                hready_in,
  input wire logic [31:0]         hrdata_out,
  // Events and core side
  input wire logic [IPF_NSRC-1:0] event_in,
  input wire logic                core_irq_enable_in,
  input wire logic                first_stack_pointer_wr_in,
  input wire logic                second_stack_pointer_wr_in,
  input wire logic                nmi_in,
  input wire logic                irq_request_out,
  input wire logic                nmi_request_out,
  input wire logic [3:0]          vector_low_out
);
  logic        s1;
  logic        s2;
  logic        rd;
  logic [15:0] ri;
  wire logic   open_g = s1 & s2;

  // Own copy of the pointer gate, so blocking is judged apart from the design
  always_ff @(posedge clk_in) begin
    rd <= !rst_in && hsel_in && hready_in && htrans_in[1] && !hwrite_in;
    ri <= haddr_in[17:2];
    if (rst_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
    end else if (first_stack_pointer_wr_in || second_stack_pointer_wr_in) begin
      s1 <= first_stack_pointer_wr_in || (s1 && !open_g);
      s2 <= second_stack_pointer_wr_in || (s2 && !open_g);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_ptsw; rd && (ri == IPF_IDX_PEND_PTIMER || ri == IPF_IDX_PEND_SWATCH)
    |-> hrdata_out[31:2] == '0; endproperty
  a_ptsw: assert property (p_ptsw)
    else $error("unused timer or stopwatch flag bits read nonzero");
  property p_one; rd && (ri == IPF_IDX_PEND_SERIAL || ri == IPF_IDX_PEND_KEY0 ||
    ri == IPF_IDX_PEND_KEY1) |-> hrdata_out[31:1] == '0; endproperty
  a_one: assert property (p_one)
    else $error("unused serial or key flag bits read nonzero");
  property p_ct; rd && ri == IPF_IDX_PEND_CTIMER |-> hrdata_out[31:4] == '0; endproperty
  a_ct: assert property (p_ct)
    else $error("clock timer flag register wider than four bits");
  property p_set; rd && ri == IPF_IDX_PEND_SERIAL && $past(event_in[IPF_SRC_SER], 2)
    |-> hrdata_out[0]; endproperty
  a_set: assert property (p_set)
    else $error("serial flag not set after its event");
  property p_unmap; rd && ri == 16'hfff0 |-> hrdata_out == '0; endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read returned data");
  property p_irq; irq_request_out |-> $past(core_irq_enable_in); endproperty
  a_irq: assert property (p_irq)
    else $error("request raised while core disabled");
  property p_blk; !open_g [*2] |=> !irq_request_out && !nmi_request_out; endproperty
  a_blk: assert property (p_blk)
    else $error("request passed a closed pointer gate");
  property p_nmi; (open_g && nmi_in) [*2] |=> nmi_request_out; endproperty
  a_nmi: assert property (p_nmi)
    else $error("nmi not passed with gate open");
  property p_vec; vector_low_out inside {4'h0, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'he};
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector nibble outside the vector table");

  c_irq: cover property (irq_request_out);
  c_nmi: cover property (nmi_request_out);
  c_read: cover property (rd && hrdata_out != '0);
endmodule : ipf_chk

bind ipf_top ipf_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .event_in(event_in),
  .core_irq_enable_in(core_irq_enable_in),
  .first_stack_pointer_wr_in(first_stack_pointer_wr_in),
  .second_stack_pointer_wr_in(second_stack_pointer_wr_in), .nmi_in(nmi_in),
  .irq_request_out(irq_request_out), .nmi_request_out(nmi_request_out),
  .vector_low_out(vector_low_out));
`default_nettype wire

/* File: dv/ipf_core_model.sv */
// Partner: behavioural core that accepts requests and writes stack pointers
`timescale 1ns/100ps
`default_nettype none
module ipf_core_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Commands from the bench
  input  wire logic       ei_in,
  input  wire logic       first_cmd_in,
  input  wire logic       second_cmd_in,
  // Block side
  input  wire logic       irq_in,
  input  wire logic [3:0] vec_in,
  output logic            ien_out,
  output logic            first_wr_out,
  output logic            second_wr_out,
  output logic [3:0]      vec_out,
  output int              taken_out
);
  always_ff @(posedge clk_in) begin
    first_wr_out  <= first_cmd_in && !rst_in;
    second_wr_out <= second_cmd_in && !rst_in;
    if (rst_in) begin
      ien_out   <= 1'b0;
      taken_out <= 0;
      vec_out   <= 4'h0;
    end else if (irq_in && ien_out) begin
      ien_out   <= 1'b0; // Entering service masks further requests
      taken_out <= taken_out + 1;
      vec_out   <= vec_in;
    end else if (ei_in) begin
      ien_out <= 1'b1;
    end
  end
endmodule : ipf_core_model
`default_nettype wire

/* File: dv/tb.sv */
// Testbench: flags, masks, pointer gate and requests of the pending-flag block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ipf_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic        hwrite = 1'b0, hready, hresp, nmi = 1'b0, irq, nmio;
  logic        ei = 1'b0, c1 = 1'b0, c2 = 1'b0, ien, wr_first, wr_second;
  logic [10:0] ev = '0;
  logic [3:0]  vec, mvec;
  int          taken, mismatches = 0, n_checks = 0;
  logic [15:0] pidx [11] = '{IPF_IDX_PEND_PTIMER, IPF_IDX_PEND_PTIMER, IPF_IDX_PEND_SERIAL,
    IPF_IDX_PEND_KEY0, IPF_IDX_PEND_KEY1, IPF_IDX_PEND_CTIMER, IPF_IDX_PEND_CTIMER,
    IPF_IDX_PEND_CTIMER, IPF_IDX_PEND_CTIMER, IPF_IDX_PEND_SWATCH, IPF_IDX_PEND_SWATCH};
  int          pbit [11] = '{0, 1, 0, 0, 0, 0, 1, 2, 3, 0, 1};
  logic [31:0] mexp [6] = '{32'h3, 32'h1, 32'h1, 32'h1, 32'hf, 32'h3};

  ipf_top dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hready),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .event_in(ev), .core_irq_enable_in(ien), .first_stack_pointer_wr_in(wr_first),
    .second_stack_pointer_wr_in(wr_second), .nmi_in(nmi), .irq_request_out(irq),
    .nmi_request_out(nmio), .vector_low_out(vec));
  ipf_core_model core (.clk_in(clk_in), .rst_in(rst_in), .ei_in(ei), .first_cmd_in(c1),
    .second_cmd_in(c2), .irq_in(irq), .vec_in(vec), .ien_out(ien),
    .first_wr_out(wr_first), .second_wr_out(wr_second), .vec_out(mvec),
    .taken_out(taken));

  initial forever #4 clk_in = ~clk_in;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge clk_in);
    htrans <= 2'b10;
    haddr  <= {14'h0, idx, 2'b00};
    hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rchk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, '0);
    chk(nm, rd, exp);
  endtask : rchk

  task automatic drive(input logic [10:0] e, input logic a, input logic b, input logic en);
    @(posedge clk_in);
    ev <= e;
    c1 <= a;
    c2 <= b;
    ei <= en;
    @(posedge clk_in);
    ev <= '0;
    c1 <= 1'b0;
    c2 <= 1'b0;
    ei <= 1'b0;
  endtask : drive

  task automatic wait_n(input int n);
    repeat (20) if (taken != n) @(posedge clk_in);
    chk("taken", taken, n);
  endtask : wait_n

  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rchk("pend_rst", IPF_IDX_PEND_PTIMER + 16'(i), '0);
      rchk("mask_rst", IPF_IDX_MASK_PTIMER + 16'(i), '0);
    end
    rchk("sp_rst", IPF_IDX_SP_CTRL, '0);
    bus(1'b1, 16'hfff0, '1);
    chk("hresp", hresp, 1'b0);
    rchk("unmapped", 16'hfff0, '0);
    for (int s = 0; s < IPF_NSRC; s++) begin
      drive(11'(1) << s, 1'b0, 1'b0, 1'b0);
      rchk("flag_set", pidx[s], 32'(1) << pbit[s]);
      bus(1'b1, pidx[s], '0);
      rchk("flag_w0", pidx[s], 32'(1) << pbit[s]);
      bus(1'b1, pidx[s], '1);
      rchk("flag_w1", pidx[s], '0);
    end
    // Event held through a read and a clear: the set must win
    ev <= 11'(1) << IPF_SRC_SER;
    rchk("flag_held", IPF_IDX_PEND_SERIAL, 32'h1);
    bus(1'b1, IPF_IDX_PEND_SERIAL, 32'h1);
    rchk("set_wins", IPF_IDX_PEND_SERIAL, 32'h1);
    ev <= '0;
    bus(1'b1, IPF_IDX_PEND_SERIAL, 32'h1);
    rchk("flag_clr", IPF_IDX_PEND_SERIAL, '0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, IPF_IDX_MASK_PTIMER + 16'(i), '1);
      rchk("mask", IPF_IDX_MASK_PTIMER + 16'(i), mexp[i]);
    end
    nmi <= 1'b1;
    drive(11'(1) << IPF_SRC_SER, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge clk_in);
    chk("blocked", {irq, nmio}, '0);
    drive('0, 1'b1, 1'b0, 1'b0);
    rchk("sp_first", IPF_IDX_SP_CTRL, 32'h1);
    chk("half", {irq, nmio, 30'(taken)}, '0);
    drive('0, 1'b0, 1'b1, 1'b0);
    wait_n(1);
    chk("vec_ser", mvec, IPF_VEC_SERIAL);
    chk("nmi_open", nmio, 1'b1);
    rchk("sp_open", IPF_IDX_SP_CTRL, 32'h4);
    drive('0, 1'b0, 1'b0, 1'b1);
    wait_n(2);
    bus(1'b1, IPF_IDX_PEND_SERIAL, 32'h1);
    drive('0, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge clk_in);
    chk("cleared", taken, 2);
    drive('0, 1'b0, 1'b1, 1'b0);
    rchk("sp_second", IPF_IDX_SP_CTRL, 32'h2);
    chk("nmi_blk", nmio, 1'b0);
    drive(11'(1) << IPF_SRC_SW1, 1'b0, 1'b0, 1'b0);
    drive(11'(1) << IPF_SRC_PT0, 1'b0, 1'b0, 1'b0);
    chk("still_blk", taken, 2);
    drive('0, 1'b1, 1'b0, 1'b0);
    wait_n(3);
    chk("vec_pt", mvec, IPF_VEC_PTIMER);
    bus(1'b1, IPF_IDX_PEND_PTIMER, 32'h1);
    drive('0, 1'b0, 1'b0, 1'b1);
    wait_n(4);
    chk("vec_sw", mvec, IPF_VEC_SWATCH);
    repeat (3) @(posedge clk_in);
    chk("core_off", irq, 1'b0);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire

/* File: hw/ipf_flag.sv */
// Module: one sticky pending flag with write-one-to-clear, set winning over clear
`timescale 1ns/100ps
`default_nettype none
module ipf_flag
  import ipf_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Event and clear
  input  wire logic set_in,
  input  wire logic clear_in,
  // Flag
  output logic      flag_out
);

  logic next_flag;

  always_comb begin
    next_flag = flag_out;
    if (clear_in) begin
      next_flag = 1'b0;
    end
    if (set_in) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flag_out <= 1'b0;
    end else begin
      flag_out <= next_flag;
    end
  end

endmodule : ipf_flag
`default_nettype wire

/* File: hw/ipf_top.sv */
// Module: interrupt pending flags, masks, stack-pointer gate and AHB-Lite register slave
// Contract
// - Flags set by events regardless of mask
// - Uncleared flag re-requests after enable or return
// - Write one clears flag, zero ignored
// - Unused bits read zero, writes ignored
// - Reset clears flags; read shows pending
// - Timer flags at D1, D0 of PTIMER_PENDING_FLAGS
// - Serial flag at D0 of SERIAL_PENDING_FLAG
// - Key group 0 flag at D0 KEYGROUP0_PENDING_FLAG
// - Key group 1 flag at D0 KEYGROUP1_PENDING_FLAG
// - Clock timer flags 1/2/8/32 Hz, CLOCK_TIMER_PENDING_FLAGS
// - Stopwatch flags 1 Hz D1, 10 Hz D0
// - Interrupts blocked until both stack pointers written
// - Single stack pointer write blocks until partner
// - Mask bits reset to zero, one enables
// - Vector low nibble by priority, 0100H-010EH
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module ipf_top
  import ipf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Peripheral event pulses, one bit per source
  input  wire logic [IPF_NSRC-1:0] event_in,
  // Core side
  input  wire logic        core_irq_enable_in,
  input  wire logic        first_stack_pointer_wr_in,
  input  wire logic        second_stack_pointer_wr_in,
  input  wire logic        nmi_in,
  output logic             irq_request_out,
  output logic             nmi_request_out,
  output logic [3:0]       vector_low_out
);

  // ----------------------------------------------------------------
  // Register bus address phase capture
  // ----------------------------------------------------------------
  logic                  wr_pend;
  logic                  next_wr_pend;
  logic [15:0]           wr_idx;
  logic [15:0]           next_wr_idx;
  logic [31:0]           rd_data;
  logic [31:0]           next_rd_data;
  logic                  access;
  logic [15:0]           a_idx;
  logic [3:0]            wnib;

  assign access        = hsel_in && hready_in && htrans_in[1];
  assign a_idx         = haddr_in[IPF_ADDR_W-1:2];
  assign wnib          = hwdata_in[IPF_REG_W-1:0];
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = rd_data;

  // ----------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------
  logic [IPF_NSRC-1:0]   mask;
  logic [IPF_NSRC-1:0]   next_mask;
  logic [IPF_NSRC-1:0]   flags;
  logic [IPF_NSRC-1:0]   clr;

  always_comb begin
    next_mask = mask;
    if (wr_pend) begin
      case (wr_idx)
        IPF_IDX_MASK_PTIMER: begin
          next_mask[IPF_SRC_PT1] = wnib[1];
          next_mask[IPF_SRC_PT0] = wnib[0];
        end
        IPF_IDX_MASK_SERIAL: next_mask[IPF_SRC_SER] = wnib[0];
        IPF_IDX_MASK_KEY0:   next_mask[IPF_SRC_K0]  = wnib[0];
        IPF_IDX_MASK_KEY1:   next_mask[IPF_SRC_K1]  = wnib[0];
        IPF_IDX_MASK_CTIMER: begin
          next_mask[IPF_SRC_CT1]  = wnib[3];
          next_mask[IPF_SRC_CT2]  = wnib[2];
          next_mask[IPF_SRC_CT8]  = wnib[1];
          next_mask[IPF_SRC_CT32] = wnib[0];
        end
        IPF_IDX_MASK_SWATCH: begin
          next_mask[IPF_SRC_SW1]  = wnib[1];
          next_mask[IPF_SRC_SW10] = wnib[0];
        end
        default: next_mask = mask;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask <= IPF_RESET_FLAGS[IPF_NSRC-1:0];
    end else begin
      mask <= next_mask;
    end
  end

  // ----------------------------------------------------------------
  // Write-one-to-clear decode; unused bits never reach a flag
  // ----------------------------------------------------------------
  always_comb begin
    clr = '0;
    if (wr_pend) begin
      case (wr_idx)
        IPF_IDX_PEND_PTIMER: begin
          clr[IPF_SRC_PT1] = wnib[1];
          clr[IPF_SRC_PT0] = wnib[0];
        end
        IPF_IDX_PEND_SERIAL: clr[IPF_SRC_SER] = wnib[0];
        IPF_IDX_PEND_KEY0:   clr[IPF_SRC_K0]  = wnib[0];
        IPF_IDX_PEND_KEY1:   clr[IPF_SRC_K1]  = wnib[0];
        IPF_IDX_PEND_CTIMER: begin
          clr[IPF_SRC_CT1]  = wnib[3];
          clr[IPF_SRC_CT2]  = wnib[2];
          clr[IPF_SRC_CT8]  = wnib[1];
          clr[IPF_SRC_CT32] = wnib[0];
        end
        IPF_IDX_PEND_SWATCH: begin
          clr[IPF_SRC_SW1]  = wnib[1];
          clr[IPF_SRC_SW10] = wnib[0];
        end
        default: clr = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags, one per source
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < IPF_NSRC; g = g + 1) begin : g_flag
      ipf_flag u_flag (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .set_in   (event_in[g]),
        .clear_in (clr[g]),
        .flag_out (flags[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Stack-pointer gate
  // ----------------------------------------------------------------
  ipf_sp_state_t sp_state;
  ipf_sp_state_t next_sp_state;
  logic          sp_first;
  logic          sp_second;

  // Both pointers written the same cycle count as a pair
  assign sp_first  = first_stack_pointer_wr_in;
  assign sp_second = second_stack_pointer_wr_in;

  always_comb begin
    next_sp_state = sp_state;
    case (sp_state)
      IPF_SP_BLOCKED, IPF_SP_OPEN: begin
        if (sp_first && sp_second) begin
          next_sp_state = IPF_SP_OPEN;
        end else if (sp_first) begin
          next_sp_state = IPF_SP_FIRST_SEEN;
        end else if (sp_second) begin
          next_sp_state = IPF_SP_SECOND_SEEN;
        end
      end
      IPF_SP_FIRST_SEEN: begin
        if (sp_second) begin
          next_sp_state = IPF_SP_OPEN;
        end
      end
      IPF_SP_SECOND_SEEN: begin
        if (sp_first) begin
          next_sp_state = IPF_SP_OPEN;
        end
      end
      default: next_sp_state = IPF_SP_BLOCKED;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sp_state <= IPF_SP_BLOCKED;
    end else begin
      sp_state <= next_sp_state;
    end
  end

  // ----------------------------------------------------------------
  // Request and vector; a flag left set keeps requesting
  // ----------------------------------------------------------------
  logic [IPF_NSRC-1:0] active;
  logic                gate_open;
  logic [3:0]          next_vec;
  logic                next_irq;
  logic                next_nmi;
  logic [3:0]          vec;
  logic                irq;
  logic                nmi;

  assign active    = flags & mask;
  assign gate_open = (sp_state == IPF_SP_OPEN);

  always_comb begin
    next_irq = gate_open && core_irq_enable_in && (|active);
    next_nmi = gate_open && nmi_in;
    if (active[IPF_SRC_PT0] || active[IPF_SRC_PT1]) begin
      next_vec = IPF_VEC_PTIMER;
    end else if (active[IPF_SRC_SER]) begin
      next_vec = IPF_VEC_SERIAL;
    end else if (active[IPF_SRC_K0]) begin
      next_vec = IPF_VEC_KEY0;
    end else if (active[IPF_SRC_K1]) begin
      next_vec = IPF_VEC_KEY1;
    end else if (|active[IPF_SRC_CT1:IPF_SRC_CT32]) begin
      next_vec = IPF_VEC_CTIMER;
    end else if (|active[IPF_SRC_SW1:IPF_SRC_SW10]) begin
      next_vec = IPF_VEC_SWATCH;
    end else begin
      next_vec = vec;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq <= 1'b0;
      nmi <= 1'b0;
      vec <= IPF_RESET_NIBBLE;
    end else begin
      irq <= next_irq;
      nmi <= next_nmi;
      vec <= next_vec;
    end
  end

  assign irq_request_out = irq;
  assign nmi_request_out = nmi;
  assign vector_low_out  = vec;

  // ----------------------------------------------------------------
  // Bus data phase: latch writes, prepare read data
  // ----------------------------------------------------------------
  always_comb begin
    next_wr_pend = access && hwrite_in;
    next_wr_idx  = access ? a_idx : wr_idx;
    next_rd_data = '0;
    if (access && !hwrite_in) begin
      case (a_idx)
        IPF_IDX_MASK_PTIMER: next_rd_data[1:0] = {mask[IPF_SRC_PT1], mask[IPF_SRC_PT0]};
        IPF_IDX_MASK_SERIAL: next_rd_data[0]   = mask[IPF_SRC_SER];
        IPF_IDX_MASK_KEY0:   next_rd_data[0]   = mask[IPF_SRC_K0];
        IPF_IDX_MASK_KEY1:   next_rd_data[0]   = mask[IPF_SRC_K1];
        IPF_IDX_MASK_CTIMER: next_rd_data[3:0] = {mask[IPF_SRC_CT1], mask[IPF_SRC_CT2],
                                                  mask[IPF_SRC_CT8], mask[IPF_SRC_CT32]};
        IPF_IDX_MASK_SWATCH: next_rd_data[1:0] = {mask[IPF_SRC_SW1], mask[IPF_SRC_SW10]};
        IPF_IDX_PEND_PTIMER: next_rd_data[1:0] = {flags[IPF_SRC_PT1], flags[IPF_SRC_PT0]};
        IPF_IDX_PEND_SERIAL: next_rd_data[0]   = flags[IPF_SRC_SER];
        IPF_IDX_PEND_KEY0:   next_rd_data[0]   = flags[IPF_SRC_K0];
        IPF_IDX_PEND_KEY1:   next_rd_data[0]   = flags[IPF_SRC_K1];
        IPF_IDX_PEND_CTIMER: next_rd_data[3:0] = {flags[IPF_SRC_CT1], flags[IPF_SRC_CT2],
                                                  flags[IPF_SRC_CT8], flags[IPF_SRC_CT32]};
        IPF_IDX_PEND_SWATCH: next_rd_data[1:0] = {flags[IPF_SRC_SW1], flags[IPF_SRC_SW10]};
        IPF_IDX_SP_CTRL: begin
          next_rd_data[IPF_SP_FIRST_BIT]  = (sp_state == IPF_SP_FIRST_SEEN);
          next_rd_data[IPF_SP_SECOND_BIT] = (sp_state == IPF_SP_SECOND_SEEN);
          next_rd_data[IPF_SP_OPEN_BIT]   = gate_open;
        end
        default: next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_pend <= 1'b0;
      wr_idx  <= '0;
      rd_data <= '0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_idx  <= next_wr_idx;
      rd_data <= next_rd_data;
    end
  end

endmodule : ipf_top
`default_nettype wire

/* File: inc/ipf_pkg.sv */
// Package: register map, field layout and constants of the interrupt pending-flag block
package ipf_pkg;

  // ----------------------------------------------------------------
  // Register indices (printed offsets are not word multiples)
  // ----------------------------------------------------------------
  localparam logic [15:0] IPF_IDX_MASK_PTIMER  = 16'hffe2;
  localparam logic [15:0] IPF_IDX_MASK_SERIAL  = 16'hffe3;
  localparam logic [15:0] IPF_IDX_MASK_KEY0    = 16'hffe4;
  localparam logic [15:0] IPF_IDX_MASK_KEY1    = 16'hffe5;
  localparam logic [15:0] IPF_IDX_MASK_CTIMER  = 16'hffe6;
  localparam logic [15:0] IPF_IDX_MASK_SWATCH  = 16'hffe7;
  localparam logic [15:0] IPF_IDX_PEND_PTIMER  = 16'hfff2;
  localparam logic [15:0] IPF_IDX_PEND_SERIAL  = 16'hfff3;
  localparam logic [15:0] IPF_IDX_PEND_KEY0    = 16'hfff4;
  localparam logic [15:0] IPF_IDX_PEND_KEY1    = 16'hfff5;
  localparam logic [15:0] IPF_IDX_PEND_CTIMER  = 16'hfff6;
  localparam logic [15:0] IPF_IDX_PEND_SWATCH  = 16'hfff7;
  // Own control/status register for the stack-pointer gate
  localparam logic [15:0] IPF_IDX_SP_CTRL      = 16'hfff8;

  localparam int          IPF_ADDR_W           = 18;
  localparam int          IPF_REG_W            = 4;

  // ----------------------------------------------------------------
  // Source numbering (index into flag vector, priority order high->low)
  // ----------------------------------------------------------------
  localparam int          IPF_NSRC             = 11;
  localparam int          IPF_SRC_PT0          = 0;
  localparam int          IPF_SRC_PT1          = 1;
  localparam int          IPF_SRC_SER          = 2;
  localparam int          IPF_SRC_K0           = 3;
  localparam int          IPF_SRC_K1           = 4;
  localparam int          IPF_SRC_CT32         = 5;
  localparam int          IPF_SRC_CT8          = 6;
  localparam int          IPF_SRC_CT2          = 7;
  localparam int          IPF_SRC_CT1          = 8;
  localparam int          IPF_SRC_SW10         = 9;
  localparam int          IPF_SRC_SW1          = 10;

  // Low-order vector nibbles (full vector is 0100H..010EH)
  localparam logic [3:0]  IPF_VEC_PTIMER       = 4'h4;
  localparam logic [3:0]  IPF_VEC_SERIAL       = 4'h6;
  localparam logic [3:0]  IPF_VEC_KEY0         = 4'h8;
  localparam logic [3:0]  IPF_VEC_KEY1         = 4'ha;
  localparam logic [3:0]  IPF_VEC_CTIMER       = 4'hc;
  localparam logic [3:0]  IPF_VEC_SWATCH       = 4'he;

  // Stack-pointer control register bits
  localparam int          IPF_SP_FIRST_BIT     = 0;
  localparam int          IPF_SP_SECOND_BIT    = 1;
  localparam int          IPF_SP_OPEN_BIT      = 2;

  localparam logic [11:0] IPF_RESET_FLAGS      = 12'h000;
  localparam logic [3:0]  IPF_RESET_NIBBLE     = 4'h0;

  typedef enum logic [1:0] {
    IPF_SP_BLOCKED,
    IPF_SP_FIRST_SEEN,
    IPF_SP_SECOND_SEEN,
    IPF_SP_OPEN
  } ipf_sp_state_t;

endpackage : ipf_pkg
